/* src/core_timer_pkg.sv */
/*
  Package for the core timer chain with its watchdog: register indices,
  field positions, reset values, the state set and the timing counts.
  Assumes a 100 MHz bus clock and a 32-bit APB slave with word registers.
*/
package core_timer_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int CLK_PERIOD_NS     = 10;          // Bus clock period
  localparam int PRESCALE_BITS     = 2;           // Counter advances every 4 clocks
  localparam int COUNTER_BITS      = 8;           // Readable ripple counter
  localparam int EXTRA_BITS        = 2;           // Stages up to the tick divider input
  localparam int TICK_BASE_BITS    = PRESCALE_BITS + COUNTER_BITS + EXTRA_BITS; // 2^12 clocks
  localparam int CHAIN_BITS        = TICK_BASE_BITS + 3;                        // Three tick stages
  localparam int STAB_CYCLES       = 4064;        // Oscillator stabilization count
  localparam int WDOG_STAGES       = 3;           // Divide by eight
  localparam int WDOG_RST_NS       = 40;          // Length of the reset pulse on timeout
  localparam int WDOG_RST_CYCLES   = (WDOG_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [15:0] IDX_CTRL_STATUS = 16'h0008;   // Control and status
  localparam logic [15:0] IDX_COUNT_VALUE = 16'h0009;   // Counter value, read only
  localparam logic [15:0] IDX_WDOG_CLEAR  = 16'h3ff0;   // Watchdog clear, write only

  // ==========================================================
  // Control and status fields
  // ==========================================================
  localparam int BIT_OVF_FLAG     = 7;   // Overflow flag, read only
  localparam int BIT_OVF_IRQ_EN   = 5;   // Overflow interrupt enable
  localparam int BIT_OVF_CLEAR    = 3;   // Write one to clear flag, reads zero
  localparam int BIT_RATE_HI      = 1;   // Tick rate select, upper bit
  localparam int BIT_RATE_LO      = 0;   // Tick rate select, lower bit
  localparam int BIT_WDOG_CLEAR   = 0;   // Written zero clears the watchdog

  localparam logic [1:0] RATE_RESET     = 2'h3;   // Slowest tick after reset
  localparam logic       IRQ_EN_RESET   = 1'b0;

  // ==========================================================
  // Reset sequencer states
  // ==========================================================
  typedef enum logic [1:0] {
    ST_POWER_HOLD,    // Power-on or low-power reset held
    ST_STABILIZE,     // Counting the stabilization period
    ST_RUN            // Normal operation
  } seq_state_t;

endpackage

/* src/core_timer_watchdog.sv */
/*
  Core timer chain with watchdog: prescaler, readable 8-bit counter with
  overflow flag, periodic tick divider with rate select, divide-by-eight
  watchdog, reset sequencer, wait-mode clock gate, APB register slave.
  Assumes synchronous APB on clk; reset pins arrive asynchronously;
  wait and stop requests come from CPU logic on the same clock.
*/
//
// Contract
// - Counter value readable, never writable by software
// - Counter advances once per four bus clocks
// - Power-on or low-power release clears, starts chain
// - After stabilization count, clear chain, leave reset
// - Without external reset, count up from zero
// - Other resets clear chain, skip stabilization
// - Watchdog divides tick output by eight
// - Watchdog timeout raises internal CPU reset
// - Watchdog clear resets only divide-by-eight stage
// - Watchdog keeps counting in wait mode
// - Disabled stop enters wait; exit clears watchdog
// - Watchdog presence fixed at build time
// - Wait stops CPU clock, timer keeps running
// - Enabled timer interrupt wakes CPU from wait
// - Watchdog always enabled in user mode
// - Overflow flag on rollover, write-one clear
// - Two more stages give bus clock over 4096
// - Two-bit rate field, reset value 11
// - Enabled overflow flag requests CPU interrupt
`timescale 1ns/1ps

module core_timer_watchdog
#(
  parameter bit WATCHDOG_PRESENT = 1'b1   // Fixed at build, no register reaches it
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        low_power_reset_input_n,
  input  wire logic        ext_reset_n,
  input  wire logic        wait_enter,
  input  wire logic        stop_enter,
  input  wire logic        irq_mask,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             cpu_irq,
  output logic             cpu_reset,
  output logic             cpu_clk_en
);
  import core_timer_pkg::*;

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [2:0]            lpr_sync_reg;        // Low-power reset pin synchroniser
  logic [2:0]            ext_sync_reg;        // External reset pin synchroniser
  logic                  lpr_n_reg;           // Filtered low-power reset level
  logic                  ext_n_reg;           // Filtered external reset level
  seq_state_t            state_reg;           // Reset sequencer
  logic [CHAIN_BITS-1:0] chain_reg;           // Whole ripple chain
  logic [2:0]            wdog_reg;            // Divide-by-eight watchdog stage
  logic [3:0]            wdog_rst_cnt_reg;    // Remaining timeout reset cycles
  logic                  ovf_flag_reg;        // Counter overflow flag
  logic                  irq_en_reg;          // Overflow interrupt enable
  logic [1:0]            rate_reg;            // Tick rate select
  logic                  stop_wait_reg;       // Wait entered through a disabled stop
  logic [31:0]           prdata_reg;
  logic                  pready_reg;
  logic                  pslverr_reg;
  logic                  cpu_irq_reg;
  logic                  cpu_reset_reg;
  logic                  cpu_clk_en_reg;
  logic                  running;             // Chain counts normally
  logic                  chain_clear;         // Clear the chain this cycle
  logic                  tick;                // Selected tap completes
  logic                  wdog_timeout;        // Final stage completes
  logic                  wr_fire;             // APB write takes effect
  logic                  rd_fire;             // APB read data is captured
  logic                  wdog_clear_wr;       // Software watchdog clear
  logic                  ovf_clear_wr;        // Software overflow flag clear
  logic                  ovf_event;           // Counter rolls from max to zero
  logic                  wake;                // Leaving wait mode

  // True when all chain bits below position n are ones
  function automatic logic low_ones(input logic [CHAIN_BITS-1:0] v, input int n);
    logic [CHAIN_BITS-1:0] mask;
    mask = CHAIN_BITS'((33'h1 << n) - 33'h1);
    return (v & mask) == mask;
  endfunction

  // Register index decode from a byte address
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] idx);
    return (addr[1:0] == 2'h0) && (addr[15:2] == idx[13:0]);
  endfunction

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  // Three flops; the level is taken only once stages two and three agree,
  // which filters a single-cycle glitch on the reset pins.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lpr_sync_reg <= 3'h0;
      ext_sync_reg <= 3'h0;
      lpr_n_reg    <= 1'b0;
      ext_n_reg    <= 1'b0;
    end
    else
    begin
      lpr_sync_reg <= {lpr_sync_reg[1:0], low_power_reset_input_n};
      ext_sync_reg <= {ext_sync_reg[1:0], ext_reset_n};
      if (lpr_sync_reg[1] == lpr_sync_reg[2])
        lpr_n_reg <= lpr_sync_reg[2];
      if (ext_sync_reg[1] == ext_sync_reg[2])
        ext_n_reg <= ext_sync_reg[2];
    end
  end

  // ==========================================================
  // Reset sequencer
  // ==========================================================
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= ST_POWER_HOLD;
    else
    begin
      unique case (state_reg)
        // Held while the low-power pin is low; leaving starts the count
        ST_POWER_HOLD:
          if (lpr_n_reg)
            state_reg <= ST_STABILIZE;
        // The chain itself counts out the stabilization period
        ST_STABILIZE:
          if (!lpr_n_reg)
            state_reg <= ST_POWER_HOLD;
          else if (low_ones(chain_reg, TICK_BASE_BITS) ||
                   (chain_reg[TICK_BASE_BITS-1:0] == TICK_BASE_BITS'(STAB_CYCLES - 1)))
            state_reg <= ST_RUN;
        ST_RUN:
          if (!lpr_n_reg)
            state_reg <= ST_POWER_HOLD;
      endcase
    end
  end

  // Chain runs outside the hold; other resets clear it with no delay
  assign running     = (state_reg == ST_RUN) && ext_n_reg && (wdog_rst_cnt_reg == 4'h0);
  assign chain_clear = (state_reg == ST_POWER_HOLD) ||
                       ((state_reg == ST_STABILIZE) && (state_reg != ST_RUN) &&
                        (chain_reg[TICK_BASE_BITS-1:0] == TICK_BASE_BITS'(STAB_CYCLES - 1))) ||
                       ((state_reg == ST_RUN) && !running);

  // ==========================================================
  // Timer chain
  // ==========================================================
  // Prescaler bits [1:0] make the counter step every fourth clock; the
  // counter sits above them and two more stages reach one 4096th.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      chain_reg <= '0;
    else if (chain_clear)
      chain_reg <= '0;
    else
      chain_reg <= chain_reg + CHAIN_BITS'(1);
  end

  // Rollover of the readable counter from its maximum back to zero
  assign ovf_event = running && low_ones(chain_reg, PRESCALE_BITS + COUNTER_BITS);

  // Selected tap from 2^12 to 2^15 clocks; changing the rate near a
  // completion may drop or add a tick, so clear the watchdog first.
  assign tick = running && low_ones(chain_reg, TICK_BASE_BITS + int'(rate_reg));

  // ==========================================================
  // Watchdog
  // ==========================================================
  assign wdog_timeout = WATCHDOG_PRESENT && tick && (wdog_reg == 3'h7);

  // Only the divide-by-eight stage is cleared; it keeps counting in wait
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wdog_reg <= 3'h0;
    else if (!running || wdog_clear_wr || (wake && stop_wait_reg))
      wdog_reg <= 3'h0;
    else if (tick)
      wdog_reg <= wdog_reg + 3'h1;
  end

  // Timeout holds the CPU in reset for a short fixed pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wdog_rst_cnt_reg <= 4'h0;
    else if (wdog_timeout)
      wdog_rst_cnt_reg <= 4'(WDOG_RST_CYCLES);
    else if (wdog_rst_cnt_reg != 4'h0)
      wdog_rst_cnt_reg <= wdog_rst_cnt_reg - 4'h1;
  end

  // ==========================================================
  // APB access decode
  // ==========================================================
  // One wait state: pready rises in the second access cycle
  assign wr_fire       = psel && penable && pready_reg && pwrite;
  assign rd_fire       = psel && penable && !pready_reg && !pwrite;
  assign wdog_clear_wr = wr_fire && hit(paddr, IDX_WDOG_CLEAR) && !pwdata[BIT_WDOG_CLEAR];
  assign ovf_clear_wr  = wr_fire && hit(paddr, IDX_CTRL_STATUS) && pwdata[BIT_OVF_CLEAR];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end
    else
    begin
      pready_reg  <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg &&
                     !(hit(paddr, IDX_CTRL_STATUS) || hit(paddr, IDX_COUNT_VALUE) ||
                       hit(paddr, IDX_WDOG_CLEAR));
      if (rd_fire)
      begin
        // Clear bit always reads zero; write-only clear address reads zero
        if (hit(paddr, IDX_CTRL_STATUS))
          prdata_reg <= {24'h0, ovf_flag_reg, 1'b0, irq_en_reg, 3'h0, rate_reg};
        else if (hit(paddr, IDX_COUNT_VALUE))
          prdata_reg <= {24'h0, chain_reg[PRESCALE_BITS +: COUNTER_BITS]};
        else
          prdata_reg <= 32'h0;
      end
    end
  end

  // ==========================================================
  // Control fields and overflow flag
  // ==========================================================
  // Counter value register has no write path at all
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_en_reg <= IRQ_EN_RESET;
      rate_reg   <= RATE_RESET;
    end
    else if (wr_fire && hit(paddr, IDX_CTRL_STATUS))
    begin
      irq_en_reg <= pwdata[BIT_OVF_IRQ_EN];
      rate_reg   <= pwdata[BIT_RATE_HI:BIT_RATE_LO];
    end
  end

  // A rollover in the same cycle as a clear keeps the flag set
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ovf_flag_reg <= 1'b0;
    else if (ovf_event)
      ovf_flag_reg <= 1'b1;
    else if (ovf_clear_wr || !running)
      ovf_flag_reg <= 1'b0;
  end

  // ==========================================================
  // CPU side: interrupt, reset, wait-mode clock gate
  // ==========================================================
  // Wake on an unmasked interrupt, or on the first running cycle after an
  // internal reset; without the second term the CPU clock never restarts
  assign wake = !cpu_clk_en_reg && ((cpu_irq_reg && !irq_mask) || cpu_reset_reg);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_irq_reg    <= 1'b0;
      cpu_reset_reg  <= 1'b1;
      cpu_clk_en_reg <= 1'b0;
      stop_wait_reg  <= 1'b0;
    end
    else
    begin
      cpu_irq_reg   <= ovf_flag_reg && irq_en_reg;
      cpu_reset_reg <= !running;
      if (!running || wake)
      begin
        cpu_clk_en_reg <= running;
        stop_wait_reg  <= 1'b0;
      end
      else if (cpu_clk_en_reg && (wait_enter || stop_enter))
      begin
        cpu_clk_en_reg <= 1'b0;
        stop_wait_reg  <= stop_enter;
      end
    end
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign cpu_irq    = cpu_irq_reg;
  assign cpu_reset  = cpu_reset_reg;
  assign cpu_clk_en = cpu_clk_en_reg;

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_ro_counter;
    @(posedge clk) disable iff (!rst_n)
      (wr_fire && hit(paddr, IDX_COUNT_VALUE) && running && $past(running)) |=>
        (chain_reg == $past(chain_reg) + CHAIN_BITS'(1)) || $past(chain_clear);
  endproperty
  a_ro_counter: assert property (p_ro_counter) else $error("Counter write disturbed chain");

  property p_prescale;
    @(posedge clk) disable iff (!rst_n)
      (running && chain_reg[1:0] == 2'h0 && !chain_clear) ##1 running [*3] |->
        $stable(chain_reg[9:2]);
  endproperty
  a_prescale: assert property (p_prescale) else $error("Counter stepped early");

  property p_hold_clear;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_POWER_HOLD) |=> (chain_reg == '0);
  endproperty
  a_hold_clear: assert property (p_hold_clear) else $error("Chain not cleared in hold");

  property p_stab_exit;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_STABILIZE && lpr_n_reg &&
       chain_reg[11:0] == 12'(STAB_CYCLES - 1)) |=> (state_reg == ST_RUN) && (chain_reg == '0);
  endproperty
  a_stab_exit: assert property (p_stab_exit) else $error("Stabilization end wrong");

  property p_ext_clear;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_RUN && !ext_n_reg) |=> (chain_reg == '0) && (state_reg != ST_STABILIZE);
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("External reset misbehaved");

  property p_wdog_rst;
    @(posedge clk) disable iff (!rst_n)
      wdog_timeout |-> ##2 cpu_reset ##1 cpu_reset;
  endproperty
  a_wdog_rst: assert property (p_wdog_rst) else $error("Timeout gave no reset");

  property p_wdog_clear_only;
    @(posedge clk) disable iff (!rst_n)
      (wdog_clear_wr && running && !chain_clear) |=>
        (wdog_reg == 3'h0) && (chain_reg == $past(chain_reg) + CHAIN_BITS'(1));
  endproperty
  a_wdog_clear_only: assert property (p_wdog_clear_only) else $error("Clear touched chain");

  property p_ovf_set;
    @(posedge clk) disable iff (!rst_n)
      ovf_event |=> ovf_flag_reg;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("Overflow flag missed");

  property p_irq;
    @(posedge clk) disable iff (!rst_n)
      (ovf_flag_reg && irq_en_reg) |=> cpu_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt not raised");

  property p_wait_runs;
    @(posedge clk) disable iff (!rst_n)
      (!cpu_clk_en && running && !chain_clear) |=> (chain_reg != $past(chain_reg));
  endproperty
  a_wait_runs: assert property (p_wait_runs) else $error("Chain stopped in wait");

  c_timeout:  cover property (@(posedge clk) disable iff (!rst_n) wdog_timeout);
  c_wake_irq: cover property (@(posedge clk) disable iff (!rst_n) wake && cpu_irq_reg);
  c_stab:     cover property (@(posedge clk) disable iff (!rst_n)
                              state_reg == ST_STABILIZE ##1 state_reg == ST_RUN);
  c_stop_wait: cover property (@(posedge clk) disable iff (!rst_n) wake && stop_wait_reg);

endmodule

/* testbench/tb_core_timer_watchdog.sv */
/*
  Self-checking bench for the core timer chain with watchdog: reset checks,
  table of counter reads, then wait, stop, watchdog and reset-path tests.
  Assumes the APB slave answers with one wait state and registered pready.
*/
`timescale 1ns/1ps

module tb_core_timer_watchdog;
  import core_timer_pkg::*;

  // ==========================================================
  // Addresses, limits and signals
  // ==========================================================
  localparam logic [15:0] A_CTRL = {IDX_CTRL_STATUS[13:0], 2'b00};  // Control and status
  localparam logic [15:0] A_CNT  = {IDX_COUNT_VALUE[13:0], 2'b00};  // Counter value
  localparam logic [15:0] A_WDOG = {IDX_WDOG_CLEAR[13:0], 2'b00};   // Watchdog clear
  localparam int          LIMIT  = 90000;                           // Whole run fits well inside

  logic        clk;
  logic        rst_n;
  logic        low_power_reset_input_n;
  logic        ext_reset_n;
  logic        wait_enter;
  logic        stop_enter;
  logic        irq_mask;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cpu_irq;
  logic        cpu_reset;
  logic        cpu_clk_en;
  int          cyc;         // Free cycle count, also the hang guard
  int          fail_count;
  int          n_tests;
  int          c1, c2, lo, real_cnt, i, r_prev;
  logic [31:0] a, b, q;
  logic        err;
  int          gaps [4] = '{0, 37, 300, 1030};  // Idle gap between the two reads
  logic        wr_between [4] = '{1'b0, 1'b1, 1'b0, 1'b1};  // Counter write inside gap

  core_timer_watchdog u_core_timer_watchdog (
    .clk                     (clk),
    .rst_n                   (rst_n),
    .low_power_reset_input_n (low_power_reset_input_n),
    .ext_reset_n             (ext_reset_n),
    .wait_enter              (wait_enter),
    .stop_enter              (stop_enter),
    .irq_mask                (irq_mask),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .prdata                  (prdata),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .cpu_irq                 (cpu_irq),
    .cpu_reset               (cpu_reset),
    .cpu_clk_en              (cpu_clk_en)
  );

  // ==========================================================
  // Clock and hang guard
  // ==========================================================
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Count cycles; a stuck wait runs into the limit and ends the run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      fail_count++;
      wrap_up();
    end
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [15:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Step to the edge at which cpu_reset shows the wanted level
  task automatic wait_reset(input logic v);
    while (cpu_reset !== v) @(posedge clk);
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    cyc = 0; fail_count = 0; n_tests = 0;
    rst_n = 1'b0; low_power_reset_input_n = 1'b1; ext_reset_n = 1'b1;
    wait_enter = 1'b0; stop_enter = 1'b0; irq_mask = 1'b1;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    repeat (5) @(posedge clk);
    check({cpu_reset, cpu_clk_en}, 2'b10);
    rst_n <= 1'b1;
    c1 = cyc;
    // Registers answer while the sequencer still holds the CPU
    apb(1'b0, A_CTRL, '0);
    check(q, 32'h3);
    apb(1'b0, 16'h0100, '0);
    check(32'(err), 32'h1);
    check(q, 32'h0);
    wait_reset(1'b0);
    check(32'((cyc - c1) >= STAB_CYCLES && (cyc - c1) <= STAB_CYCLES + 12), 32'h1);
    apb(1'b0, A_CNT, '0);
    check(32'(q < 32'h10), 32'h1);
    // Table: counter pace across gaps, writes to the counter, wrap flag
    r_prev = 1;
    for (i = 0; i < 4; i++)
    begin
      apb(1'b0, A_CNT, '0);
      a = q; c1 = cyc;
      if (wr_between[i]) apb(1'b1, A_CNT, 32'h0);
      repeat (gaps[i]) @(posedge clk);
      apb(1'b0, A_CNT, '0);
      b = q; c2 = cyc;
      lo = (c2 - c1) / 4;
      real_cnt = (((b - a) & 32'hff) == ((lo + 1) & 32'hff)) ? lo + 1 : lo;
      check((b - a) & 32'hff, real_cnt & 32'hff);
      apb(1'b0, A_CTRL, '0);
      // Counter is exactly b+1 here; an a of zero means a wrap since the last clear
      if (r_prev != 0)
        check(q[BIT_OVF_FLAG], 32'(a == 0 || (a + real_cnt + 1) >= 256));
      apb(1'b1, A_CTRL, 32'h0b);
      apb(1'b0, A_CTRL, '0);
      // Counter is b+3 here; only a wrap onto zero can race the clear
      r_prev = (b + 3) & 32'hff;
      if (r_prev != 0) check(q, 32'h3);
    end
    // Wait mode: masked interrupt keeps the CPU halted, unmasked wakes it
    apb(1'b1, A_CTRL, 32'h28);
    wait_enter <= 1'b1;
    @(posedge clk);
    wait_enter <= 1'b0;
    repeat (2) @(posedge clk);
    check(cpu_clk_en, 1'b0);
    apb(1'b0, A_CNT, '0);
    a = q;
    repeat (20) @(posedge clk);
    apb(1'b0, A_CNT, '0);
    check(32'(q != a), 32'h1);
    while (cpu_irq !== 1'b1) @(posedge clk);
    repeat (3) @(posedge clk);
    check({cpu_irq, cpu_clk_en}, 2'b10);
    irq_mask <= 1'b0;
    repeat (3) @(posedge clk);
    check(cpu_clk_en, 1'b1);
    apb(1'b1, A_CTRL, 32'h28);
    repeat (3) @(posedge clk);
    check(cpu_irq, 1'b0);
    // Watchdog: clear, then stop-as-wait; leaving it restarts the count
    apb(1'b1, A_WDOG, 32'h0);
    repeat (20000) @(posedge clk);
    apb(1'b1, A_CTRL, 32'h28);
    stop_enter <= 1'b1;
    @(posedge clk);
    stop_enter <= 1'b0;
    repeat (2) @(posedge clk);
    check(cpu_clk_en, 1'b0);
    while (cpu_clk_en !== 1'b1) @(posedge clk);
    c1 = cyc;
    check(cpu_reset, 1'b0);
    apb(1'b1, A_CTRL, 32'h08);
    wait_reset(1'b1);
    check(32'((cyc - c1) >= 28672 && (cyc - c1) <= 32800), 32'h1);
    c1 = cyc;
    wait_reset(1'b0);
    check(32'((cyc - c1) <= 20), 32'h1);
    apb(1'b0, A_CNT, '0);
    check(32'(q < 32'h10), 32'h1);
    // External reset clears the chain without the long count
    ext_reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    check(cpu_reset, 1'b1);
    ext_reset_n <= 1'b1;
    c1 = cyc;
    wait_reset(1'b0);
    check(32'((cyc - c1) <= 20), 32'h1);
    apb(1'b0, A_CNT, '0);
    check(32'(q < 32'h10), 32'h1);
    // Low-power pin runs the whole stabilization again
    low_power_reset_input_n <= 1'b0;
    // Synchroniser, then the hold state, then the registered reset output
    repeat (8) @(posedge clk);
    check(cpu_reset, 1'b1);
    low_power_reset_input_n <= 1'b1;
    c1 = cyc;
    wait_reset(1'b0);
    check(32'((cyc - c1) >= STAB_CYCLES && (cyc - c1) <= STAB_CYCLES + 12), 32'h1);
    apb(1'b0, A_CNT, '0);
    check(32'(q < 32'h10), 32'h1);
    wrap_up();
  end

endmodule
